// ### design/crc_defines.svh
// Purpose: Offsets, field positions, reset values and timing counts of the clock/reset control
// Assumes: Included by bare name; definitions only
// Notes:   Byte offsets within the slave's window
`ifndef CRC_DEFINES_SVH
`define CRC_DEFINES_SVH

`define CRC_ADDR_W          12
`define CRC_OFS_CTRL        12'h000
`define CRC_OFS_CFG         12'h004
`define CRC_OFS_CLKINT      12'h008
`define CRC_OFS_FAST_RST    12'h00c
`define CRC_OFS_SLOW_RST    12'h010
`define CRC_OFS_BUS_CLK     12'h014

`define CRC_CTRL_AUDIO      24
`define CRC_CTRL_EXT_RDY    17
`define CRC_CTRL_EXT_ON     16
`define CRC_CTRL_TRIM_MSB   15
`define CRC_CTRL_TRIM_LSB   8
`define CRC_CTRL_INT_RDY    1
`define CRC_CTRL_INT_ON     0

`define CRC_CFG_CLKOUT_LSB  25
`define CRC_CFG_INT_DIV     16
`define CRC_CFG_FAST_LSB    11
`define CRC_CFG_SLOW_LSB    8
`define CRC_CFG_SYS_LSB     4
`define CRC_CFG_STS         2
`define CRC_CFG_REQ         0

`define CRC_INT_CLR_LSB     16
`define CRC_INT_ON_LSB      8
`define CRC_INT_FLAG_LSB    0

`define CRC_CFG_MASK        32'h1e01_3f35
`define CRC_FAST_RST_MASK   32'h0000_560d
`define CRC_SLOW_RST_MASK   32'h1022_0812
`define CRC_BUS_CLK_MASK    32'h0000_5045
`define CRC_BUS_CLK_ONES    32'h0000_0010

`define CRC_RST_EXT_ON      1'b1
`define CRC_RST_INT_ON      1'b1
`define CRC_RST_TRIM        8'h0d
`define CRC_RST_BUS_CLK     32'h0000_0004

`define CRC_CLK_PERIOD_NS   8
`define CRC_EXT_DROP_NS     100
`define CRC_EXT_DROP_CYC    (`CRC_EXT_DROP_NS / `CRC_CLK_PERIOD_NS)
`define CRC_INT_DROP_TICKS  3'h6

`endif

// ### design/crc_pkg.sv
// Purpose: Types and shared decode for the clock/reset control
// Assumes: Nothing beyond the tool's SystemVerilog support
// Notes:   Constants live in crc_defines.svh
package crc_pkg;

    typedef enum logic [1:0] {
        CRC_BUS_IDLE,
        CRC_BUS_WRITE,
        CRC_BUS_READ
    } crc_bus_t;

    typedef struct packed {
        crc_bus_t    bus_st;
        logic [11:0] addr;
        logic        hreadyout;
        logic [31:0] hrdata;
        logic        hresp;
        logic        audio_on;
        logic        ext_on;
        logic        int_on;
        logic [7:0]  trim;
        logic        ext_rdy;
        logic        int_rdy;
        logic [2:0]  int_drop_cnt;
        logic [3:0]  clk_out_sel;
        logic        int_div_sel;
        logic [2:0]  fast_div;
        logic [2:0]  slow_div;
        logic [1:0]  sys_div;
        logic        sw_req;
        logic        sw_sts;
        logic [3:0]  irq_on;
        logic [3:0]  irq_flag;
        logic [3:0]  rdy_prev;
        logic [31:0] fast_rst;
        logic [31:0] slow_rst;
        logic [31:0] bus_clk;
    } crc_state_t;

    typedef struct packed {
        logic [3:0] cnt;
        logic       tick;
    } crc_div_state_t;

    // Peripheral bus codes 0xx pass through, 1xx divide by 2..16
    function automatic logic [2:0] crc_apb_shift(input logic [2:0] code);
        crc_apb_shift = code[2] ? ({1'b0, code[1:0]} + 3'h1) : 3'h0;
    endfunction : crc_apb_shift

endpackage : crc_pkg

// ### design/crc_tick_div.sv
// Purpose: Divides an enable pulse train by 2**shift
// Assumes: shift at most 4
// Notes:   A change of shift takes effect at the next wrap or at once if the count is past it
`timescale 1ns/1ps
`default_nettype none
module crc_tick_div
    import crc_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    input  wire logic       tick_in,
    input  wire logic [2:0] shift,
    output logic            tick_out
);
    crc_div_state_t st_reg;
    crc_div_state_t st_next;
    logic [4:0]     limit;

    always_comb begin
        st_next = st_reg;
        st_next.tick = 1'b0;
        limit = (5'h1 << shift) - 5'h1;
        if (tick_in) begin
            if ({1'b0, st_reg.cnt} >= limit) begin
                st_next.cnt = 4'h0;
                st_next.tick = 1'b1;
            end else begin
                st_next.cnt = st_reg.cnt + 4'h1;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign tick_out = st_reg.tick;

endmodule : crc_tick_div
`default_nettype wire

// ### design/crc_clock_reset_ctrl.sv
// Purpose: Register-controlled part of the clock and reset unit, AHB-Lite slave
// Assumes: Oscillator status and power-mode events are synchronous to sys_clk
// Notes:   Reads take one wait state, writes none
//
// Added by the designer: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "crc_defines.svh"
//
// Function
// - Enable bits turn audio PLL, oscillators on
// - External ready set when stable, drops fast
// - Internal ready clears six oscillator ticks later
// - Sleep clears external enable, wake restores
// - Sleep clears internal enable, wake restores
// - Active system clock source cannot be disabled by a register write
// - Eight-bit internal oscillator trim value
// - Four-bit clock output source select
// - Internal divider select writable only when off
// - Fast peripheral bus prescaler divides AHB
// - Slow peripheral bus prescaler divides AHB
// - AHB prescaler divides system clock
// - Software requests system clock source
// - Status shows source actually clocking system
// - Four ready interrupt enable bits
// - Ready flag set on enabled ready, sticky
// - Writing one to clear bit clears flag
// - Fast bus peripheral reset hold bits
// - Slow bus peripheral reset hold bits
// - Source switch waits for target ready
module crc_clock_reset_ctrl
    import crc_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    input  wire logic        ext_fast_osc_stable,
    input  wire logic        int_fast_osc_stable,
    input  wire logic        int_fast_osc_tick,
    input  wire logic        ext_slow_osc_ready,
    input  wire logic        int_slow_osc_ready,
    input  wire logic        sleep_entry,
    input  wire logic        pd_entry,
    input  wire logic        sleep_exit,
    output logic             audio_pll_on,
    output logic             ext_fast_osc_on,
    output logic             int_fast_osc_on,
    output logic             ext_fast_osc_ready,
    output logic             int_fast_osc_ready,
    output logic [7:0]       int_fast_trim,
    output logic             int_fast_divider_select,
    output logic [3:0]       clock_out_select,
    output logic             system_clock_source_status,
    output logic             system_bus_clk_en,
    output logic             fast_periph_bus_clk_en,
    output logic             slow_periph_bus_clk_en,
    output logic [3:0]       ready_irq_flags,
    output logic [31:0]      fast_bus_hold,
    output logic [31:0]      slow_bus_hold,
    output logic [31:0]      bus_clk_enable
);
    localparam int EXT_DROP = `CRC_EXT_DROP_CYC;

    crc_state_t st_reg;
    crc_state_t st_next;
    logic       taken;
    logic       wr_now;
    logic [3:0] irq_clr;
    logic [3:0] rdy_now;
    logic [2:0] sys_shift;
    logic       ahb_tick;

    // The size is ignored: only whole-word transfers reach this slave
    assign taken   = hsel && htrans[1] && hready;
    assign wr_now  = (st_reg.bus_st == CRC_BUS_WRITE);
    assign irq_clr = (wr_now && st_reg.addr == `CRC_OFS_CLKINT) ?
                     hwdata[`CRC_INT_CLR_LSB +: 4] : 4'h0;
    assign rdy_now = {st_reg.ext_rdy, st_reg.int_rdy, ext_slow_osc_ready, int_slow_osc_ready};
    assign sys_shift = {1'b0, st_reg.sys_div[1] & st_reg.sys_div[0],
                        st_reg.sys_div[1] & ~st_reg.sys_div[0]};

    function automatic logic [31:0] read_word(input crc_state_t s);
        read_word = 32'h0;
        unique case (s.addr)
            `CRC_OFS_CTRL: begin
                read_word[`CRC_CTRL_AUDIO]   = s.audio_on;
                read_word[`CRC_CTRL_EXT_RDY] = s.ext_rdy;
                read_word[`CRC_CTRL_EXT_ON]  = s.ext_on;
                read_word[`CRC_CTRL_TRIM_MSB] = s.trim[7];
                read_word[`CRC_CTRL_TRIM_LSB +: 7] = s.trim[6:0];
                read_word[`CRC_CTRL_INT_RDY] = s.int_rdy;
                read_word[`CRC_CTRL_INT_ON]  = s.int_on;
            end
            `CRC_OFS_CFG: begin
                read_word[`CRC_CFG_CLKOUT_LSB +: 4] = s.clk_out_sel;
                read_word[`CRC_CFG_INT_DIV]      = s.int_div_sel;
                read_word[`CRC_CFG_FAST_LSB +: 3] = s.fast_div;
                read_word[`CRC_CFG_SLOW_LSB +: 3] = s.slow_div;
                read_word[`CRC_CFG_SYS_LSB +: 2]  = s.sys_div;
                read_word[`CRC_CFG_STS]          = s.sw_sts;
                read_word[`CRC_CFG_REQ]          = s.sw_req;
            end
            `CRC_OFS_CLKINT: begin
                read_word[`CRC_INT_ON_LSB +: 4]   = s.irq_on;
                read_word[`CRC_INT_FLAG_LSB +: 4] = s.irq_flag;
            end
            `CRC_OFS_FAST_RST: read_word = s.fast_rst;
            `CRC_OFS_SLOW_RST: read_word = s.slow_rst;
            `CRC_OFS_BUS_CLK:  read_word = s.bus_clk | `CRC_BUS_CLK_ONES;
            default:           read_word = 32'h0;
        endcase
    endfunction : read_word

    always_comb begin
        st_next = st_reg;
        st_next.hresp = 1'b0;

        // Register writes land in the data phase, with no wait state
        if (wr_now) begin
            unique case (st_reg.addr)
                `CRC_OFS_CTRL: begin
                    st_next.audio_on = hwdata[`CRC_CTRL_AUDIO];
                    st_next.ext_on = hwdata[`CRC_CTRL_EXT_ON] |
                                     (st_reg.sw_sts & st_reg.ext_on);
                    st_next.int_on = hwdata[`CRC_CTRL_INT_ON] |
                                     (~st_reg.sw_sts & st_reg.int_on);
                    st_next.trim = {hwdata[`CRC_CTRL_TRIM_MSB],
                                    hwdata[`CRC_CTRL_TRIM_LSB +: 7]};
                end
                `CRC_OFS_CFG: begin
                    st_next.clk_out_sel = hwdata[`CRC_CFG_CLKOUT_LSB +: 4];
                    if (!st_reg.int_on) begin
                        st_next.int_div_sel = hwdata[`CRC_CFG_INT_DIV];
                    end
                    st_next.fast_div = hwdata[`CRC_CFG_FAST_LSB +: 3];
                    st_next.slow_div = hwdata[`CRC_CFG_SLOW_LSB +: 3];
                    st_next.sys_div  = hwdata[`CRC_CFG_SYS_LSB +: 2];
                    st_next.sw_req   = hwdata[`CRC_CFG_REQ];
                end
                `CRC_OFS_CLKINT: begin
                    st_next.irq_on = hwdata[`CRC_INT_ON_LSB +: 4];
                end
                `CRC_OFS_FAST_RST: st_next.fast_rst = hwdata & `CRC_FAST_RST_MASK;
                `CRC_OFS_SLOW_RST: st_next.slow_rst = hwdata & `CRC_SLOW_RST_MASK;
                `CRC_OFS_BUS_CLK:  st_next.bus_clk = hwdata & `CRC_BUS_CLK_MASK;
                default: begin
                end
            endcase
        end

        // Power-mode events outrank software, so a write in the same cycle loses
        if (sleep_entry || pd_entry) begin
            st_next.ext_on = 1'b0;
            st_next.int_on = 1'b0;
        end else if (sleep_exit) begin
            st_next.ext_on = 1'b1;
            st_next.int_on = 1'b1;
        end

        // External ready follows the stored enable, so it drops one cycle after the clear
        st_next.ext_rdy = st_reg.ext_on & ext_fast_osc_stable;
        if (st_reg.int_on) begin
            st_next.int_rdy = int_fast_osc_stable;
            st_next.int_drop_cnt = 3'h0;
        end else if (st_reg.int_rdy && int_fast_osc_tick) begin
            if (st_reg.int_drop_cnt == `CRC_INT_DROP_TICKS - 3'h1) begin
                st_next.int_rdy = 1'b0;
                st_next.int_drop_cnt = 3'h0;
            end else begin
                st_next.int_drop_cnt = st_reg.int_drop_cnt + 3'h1;
            end
        end

        // Switch only once the target reports ready; otherwise keep waiting
        if (st_reg.sw_req != st_reg.sw_sts) begin
            if (st_reg.sw_req ? st_reg.ext_rdy : st_reg.int_rdy) begin
                st_next.sw_sts = st_reg.sw_req;
            end
        end

        // A ready edge in the clear cycle still sets the flag
        st_next.rdy_prev = rdy_now;
        st_next.irq_flag = (st_reg.irq_flag & ~irq_clr) |
                           (st_reg.irq_on & rdy_now & ~st_reg.rdy_prev);

        // Bus slave: new address phases accepted while ready is high
        unique case (st_reg.bus_st)
            CRC_BUS_READ: begin
                st_next.hrdata = read_word(st_reg);
                st_next.hreadyout = 1'b1;
                st_next.bus_st = CRC_BUS_IDLE;
            end
            CRC_BUS_IDLE, CRC_BUS_WRITE: begin
                st_next.bus_st = CRC_BUS_IDLE;
                if (taken) begin
                    st_next.addr = haddr[`CRC_ADDR_W-1:0];
                    if (haddr[31:`CRC_ADDR_W] != '0) begin
                        st_next.addr = 12'hfff;
                    end
                    st_next.bus_st = hwrite ? CRC_BUS_WRITE : CRC_BUS_READ;
                    st_next.hreadyout = hwrite;
                end
            end
            default: begin
                st_next.bus_st = CRC_BUS_IDLE;
                st_next.hreadyout = 1'b1;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '0;
            st_reg.bus_st <= CRC_BUS_IDLE;
            st_reg.hreadyout <= 1'b1;
            st_reg.ext_on <= `CRC_RST_EXT_ON;
            st_reg.int_on <= `CRC_RST_INT_ON;
            st_reg.trim <= `CRC_RST_TRIM;
            st_reg.bus_clk <= `CRC_RST_BUS_CLK;
        end else begin
            st_reg <= st_next;
        end
    end

    crc_tick_div u_sys_div (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n),
        .tick_in  (1'b1),
        .shift    (sys_shift),
        .tick_out (ahb_tick)
    );

    crc_tick_div u_fast_div (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n),
        .tick_in  (ahb_tick),
        .shift    (crc_apb_shift(st_reg.fast_div)),
        .tick_out (fast_periph_bus_clk_en)
    );

    crc_tick_div u_slow_div (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n),
        .tick_in  (ahb_tick),
        .shift    (crc_apb_shift(st_reg.slow_div)),
        .tick_out (slow_periph_bus_clk_en)
    );

    assign system_bus_clk_en       = ahb_tick;
    assign hreadyout               = st_reg.hreadyout;
    assign hrdata                  = st_reg.hrdata;
    assign hresp                   = st_reg.hresp;
    assign audio_pll_on            = st_reg.audio_on;
    assign ext_fast_osc_on         = st_reg.ext_on;
    assign int_fast_osc_on         = st_reg.int_on;
    assign ext_fast_osc_ready      = st_reg.ext_rdy;
    assign int_fast_osc_ready      = st_reg.int_rdy;
    assign int_fast_trim           = st_reg.trim;
    assign int_fast_divider_select = st_reg.int_div_sel;
    assign clock_out_select        = st_reg.clk_out_sel;
    assign system_clock_source_status    = st_reg.sw_sts;
    assign ready_irq_flags         = st_reg.irq_flag;
    assign fast_bus_hold           = st_reg.fast_rst;
    assign slow_bus_hold           = st_reg.slow_rst;
    assign bus_clk_enable          = st_reg.bus_clk | `CRC_BUS_CLK_ONES;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    a_ext_ready_drop: assert property (
        !st_reg.ext_on |-> ##[1:EXT_DROP] !st_reg.ext_rdy)
        else $error("external ready did not drop after disable");

    a_int_ready_count: assert property (
        $fell(st_reg.int_rdy) && !$past(st_reg.int_on) |->
        $past(st_reg.int_drop_cnt) == 3'h5 && $past(int_fast_osc_tick))
        else $error("internal ready cleared on the wrong tick");

    a_sleep_clears_on: assert property (
        (sleep_entry || pd_entry) |=> !st_reg.ext_on && !st_reg.int_on)
        else $error("sleep entry left an oscillator enabled");

    a_wake_restarts_osc: assert property (
        sleep_exit && !sleep_entry && !pd_entry |=> st_reg.ext_on && st_reg.int_on)
        else $error("wake did not restart oscillators");

    a_active_src_kept: assert property (
        st_reg.sw_sts && st_reg.ext_on && !sleep_entry && !pd_entry |=> st_reg.ext_on)
        else $error("active external source was disabled");

    a_int_src_kept: assert property (
        !st_reg.sw_sts && st_reg.int_on && !sleep_entry && !pd_entry |=> st_reg.int_on)
        else $error("active internal source was disabled");

    a_switch_waits_ready: assert property (
        $changed(st_reg.sw_sts) |->
        $past(st_reg.sw_req) == st_reg.sw_sts &&
        (st_reg.sw_sts ? $past(st_reg.ext_rdy) : $past(st_reg.int_rdy)))
        else $error("clock switched before target ready");

    a_flag_sticky: assert property (
        st_reg.irq_flag[3] && !irq_clr[3] |=> st_reg.irq_flag[3])
        else $error("ready flag dropped without a clear");

    a_flag_clear: assert property (
        irq_clr[2] && !(st_reg.irq_on[2] && rdy_now[2] && !st_reg.rdy_prev[2])
        |=> !st_reg.irq_flag[2])
        else $error("clear bit did not clear ready flag");

    a_cfg_reserved_zero: assert property (
        $past(st_reg.bus_st == CRC_BUS_READ) && st_reg.addr == `CRC_OFS_CFG |->
        st_reg.hreadyout && (st_reg.hrdata & ~`CRC_CFG_MASK) == 32'h0)
        else $error("reserved configuration bits read nonzero");

    a_hold_reserved_zero: assert property (
        ((st_reg.fast_rst & ~`CRC_FAST_RST_MASK) | (st_reg.slow_rst & ~`CRC_SLOW_RST_MASK)) == 32'h0)
        else $error("reserved peripheral hold bit set");

    a_div_sel_locked: assert property (
        st_reg.int_on |=> $stable(st_reg.int_div_sel))
        else $error("divider select changed while oscillator on");

    a_trim_kept: assert property (
        !(wr_now && st_reg.addr == `CRC_OFS_CTRL) |=> $stable(st_reg.trim))
        else $error("trim changed without a control write");

    a_flag_needs_en: assert property (
        (st_reg.irq_flag & ~$past(st_reg.irq_flag) & ~$past(st_reg.irq_on)) == 4'h0)
        else $error("ready flag set while its enable was off");

    a_ext_rdy_needs_on: assert property (
        st_reg.ext_rdy |-> $past(st_reg.ext_on))
        else $error("external ready high while oscillator off");

    c_switch_to_ext: cover property (st_reg.sw_req ##[1:50] st_reg.sw_sts);
    c_sleep_wake: cover property (sleep_entry ##[1:50] sleep_exit);
    c_flag_set: cover property ($rose(st_reg.irq_flag[3]));
    c_read_done: cover property (st_reg.bus_st == CRC_BUS_READ ##1 st_reg.hreadyout);

endmodule : crc_clock_reset_ctrl
`default_nettype wire

// ### verification/crc_clock_reset_ctrl_tb_top.sv
// Purpose: Self-checking bench for the clock/reset control AHB-Lite slave
// Assumes: Bench is the only bus master; oscillator and power inputs come from the bench
// Notes:   Master waits on hready, never on a fixed read latency
`timescale 1ns/1ps
`default_nettype none
`include "crc_defines.svh"
module crc_clock_reset_ctrl_tb_top;
    localparam logic [31:0] CK = 32'h0101_a501;
    localparam logic [31:0] EXT = 32'h0001_0000;
    logic        sys_clk, rst_n, hsel, hwrite, hreadyout, hresp, tick;
    logic [31:0] haddr, hwdata, hrdata, fast_hold, slow_hold, bus_clk;
    logic [1:0]  htrans;
    logic [2:0]  hsize, pwr_ev;
    logic [3:0]  osc_st, flags, clk_sel;
    logic        audio, ext_on, int_on, ext_rdy, int_rdy, div_sel, sts, sys_en, fast_en, slow_en;
    logic [7:0]  trim;
    int          bad_count, cmp_count, cycles;

    crc_clock_reset_ctrl DUT (.sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .ext_fast_osc_stable(osc_st[3]), .int_fast_osc_stable(osc_st[2]),
        .int_fast_osc_tick(tick), .ext_slow_osc_ready(osc_st[1]),
        .int_slow_osc_ready(osc_st[0]), .sleep_entry(pwr_ev[0]), .pd_entry(pwr_ev[1]),
        .sleep_exit(pwr_ev[2]), .audio_pll_on(audio), .ext_fast_osc_on(ext_on),
        .int_fast_osc_on(int_on), .ext_fast_osc_ready(ext_rdy), .int_fast_osc_ready(int_rdy),
        .int_fast_trim(trim), .int_fast_divider_select(div_sel), .clock_out_select(clk_sel),
        .system_clock_source_status(sts), .system_bus_clk_en(sys_en),
        .fast_periph_bus_clk_en(fast_en), .slow_periph_bus_clk_en(slow_en),
        .ready_irq_flags(flags), .fast_bus_hold(fast_hold), .slow_bus_hold(slow_hold),
        .bus_clk_enable(bus_clk));

    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    task automatic stop_test();
        if (bad_count == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : stop_test

    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            bad_count++;
            stop_test();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : cyc

    // Read data is taken at the edge that closes the data phase, before it can move
    task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d,
                        output logic [31:0] q);
        @(posedge sys_clk);
        hsel   <= 1'b1;
        haddr  <= a;
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        q = hrdata;
        #1;
    endtask : xfer

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(a, 1'b1, d, q);
    endtask : wr

    task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] q;
        xfer(a, 1'b0, 32'h0, q);
        chk(q, exp);
        chk(hresp, 1'b0);
    endtask : rdc

    task automatic pwr(input logic [2:0] e);
        @(posedge sys_clk);
        pwr_ev <= e;
        @(posedge sys_clk);
        pwr_ev <= 3'h0;
        cyc(1);
    endtask : pwr

    task automatic pulse_tick();
        @(posedge sys_clk);
        tick <= 1'b1;
        @(posedge sys_clk);
        tick <= 1'b0;
    endtask : pulse_tick

    task automatic t_reset_regs();
        rdc(`CRC_OFS_CTRL, 32'h0001_0d01);
        rdc(`CRC_OFS_CFG, 32'h0);
        rdc(`CRC_OFS_BUS_CLK, 32'h0000_0014);
        chk(trim, 8'h0d);
        wr(`CRC_OFS_CTRL, CK);
        chk(audio, 1'b1);
        chk(trim, 8'ha5);
        rdc(`CRC_OFS_CTRL, CK);
        wr(`CRC_OFS_FAST_RST, 32'hffff_ffff);
        rdc(`CRC_OFS_FAST_RST, 32'h0000_560d);
        chk(fast_hold, 32'h0000_560d);
        wr(`CRC_OFS_SLOW_RST, 32'hffff_ffff);
        chk(slow_hold, 32'h1022_0812);
        wr(`CRC_OFS_SLOW_RST, 32'h0);
        rdc(`CRC_OFS_SLOW_RST, 32'h0);
        wr(`CRC_OFS_BUS_CLK, 32'h0);
        rdc(`CRC_OFS_BUS_CLK, 32'h0000_0010);
        chk(bus_clk, 32'h0000_0010);
        wr(32'h0000_0018, 32'hffff_ffff);
        rdc(32'h0000_0018, 32'h0);
        rdc(32'h0000_1004, 32'h0);
        wr(`CRC_OFS_CFG, 32'he1fe_c0ca);
        rdc(`CRC_OFS_CFG, 32'h0);
        for (int i = 0; i < 8; i++) begin
            wr(`CRC_OFS_CFG, 32'(i) << 25);
            chk(clk_sel, 4'(i));
        end
    endtask : t_reset_regs

    task automatic t_flags();
        wr(`CRC_OFS_CLKINT, 32'h0000_0e00);
        @(posedge sys_clk);
        osc_st <= 4'hf;
        cyc(3);
        chk(flags, 4'he);
        chk(ext_rdy, 1'b1);
        chk(int_rdy, 1'b1);
        rdc(`CRC_OFS_CLKINT, 32'h0000_0e0e);
        wr(`CRC_OFS_CLKINT, 32'h0000_0e00);
        chk(flags, 4'he);
        wr(`CRC_OFS_CLKINT, 32'h0008_0e00);
        chk(flags, 4'h6);
        wr(`CRC_OFS_CLKINT, 32'h0007_0e00);
        rdc(`CRC_OFS_CLKINT, 32'h0000_0e00);
    endtask : t_flags

    task automatic t_switch();
        wr(`CRC_OFS_CTRL, CK & ~EXT);
        cyc(`CRC_EXT_DROP_CYC);
        chk(ext_rdy, 1'b0);
        wr(`CRC_OFS_CFG, 32'h1);
        cyc(4);
        chk(sts, 1'b0);
        wr(`CRC_OFS_CTRL, CK);
        cyc(4);
        chk(sts, 1'b1);
        rdc(`CRC_OFS_CFG, 32'h5);
        wr(`CRC_OFS_CTRL, CK & ~EXT);
        chk(ext_on, 1'b1);
        wr(`CRC_OFS_CFG, 32'h0001_0001);
        rdc(`CRC_OFS_CFG, 32'h5);
        wr(`CRC_OFS_CTRL, CK & ~32'h1);
        chk(int_on, 1'b0);
        cyc(1);
        repeat (5) pulse_tick();
        cyc(0);
        chk(int_rdy, 1'b1);
        pulse_tick();
        cyc(2);
        chk(int_rdy, 1'b0);
        wr(`CRC_OFS_CFG, 32'h0001_0001);
        chk(div_sel, 1'b1);
        wr(`CRC_OFS_CTRL, CK);
        cyc(4);
        wr(`CRC_OFS_CFG, 32'h0);
        cyc(4);
        chk(sts, 1'b0);
        wr(`CRC_OFS_CTRL, CK & ~32'h1);
        chk(int_on, 1'b1);
    endtask : t_switch

    task automatic t_sleep();
        pwr(3'b001);
        chk({ext_on, int_on}, 2'b00);
        pwr(3'b100);
        chk({ext_on, int_on}, 2'b11);
        pwr(3'b010);
        chk({ext_on, int_on}, 2'b00);
        pwr(3'b100);
        chk({ext_on, int_on}, 2'b11);
    endtask : t_sleep

    // Counting over a whole number of divider periods makes the totals exact
    task automatic t_div();
        logic [31:0] cfg [4] = '{32'h0000_3c30, 32'h0000_1e00, 32'h0000_3510, 32'h0000_2720};
        int          exp [4][3] = '{'{16, 1, 8}, '{64, 64, 8}, '{64, 8, 16}, '{32, 16, 2}};
        int          n [3];
        for (int k = 0; k < 4; k++) begin
            wr(`CRC_OFS_CFG, cfg[k]);
            cyc(80);
            n = '{0, 0, 0};
            repeat (64) begin
                @(posedge sys_clk);
                n[0] += int'(sys_en === 1'b1);
                n[1] += int'(fast_en === 1'b1);
                n[2] += int'(slow_en === 1'b1);
            end
            chk(n[0], exp[k][0]);
            chk(n[1], exp[k][1]);
            chk(n[2], exp[k][2]);
        end
    endtask : t_div

    initial begin
        bad_count = 0;
        cmp_count = 0;
        cycles = 0;
        rst_n = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        tick = 1'b0;
        osc_st = 4'h0;
        pwr_ev = 3'h0;
        repeat (12) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_reset_regs();
        t_flags();
        t_switch();
        t_sleep();
        t_div();
        stop_test();
    end
endmodule : crc_clock_reset_ctrl_tb_top
`default_nettype wire
